// >>> hdl/apf_pkg.sv
`default_nettype none
package apf_pkg;
    localparam int APF_DATA_W = 8;
    localparam int APF_FIFO_DEPTH = 16;
    // Mode selector value that enables the async FIFO port on a channel
    localparam logic [1:0] APF_MODE_ASYNC_FIFO = 2'h1;
    localparam logic [1:0] APF_MODE_OFF = 2'h0;

    typedef struct packed {
        logic rd_n;
        logic wr_n;
        logic send_now_wakeup_n;
    } apf_strobes_t;

    typedef struct packed {
        logic usb_active_n;
        logic remote_wakeup_en;
    } apf_usb_state_t;
endpackage : apf_pkg
`default_nettype wire

// >>> hdl/apf_fifo.sv
`default_nettype none
module apf_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] count;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    assign in_ready = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data = mem[rp];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp <= '0;
            rp <= '0;
            count <= '0;
        end else begin
            if (push) wp <= (wp == AW'(DEPTH-1)) ? '0 : wp + 1'b1;
            if (pop) rp <= (rp == AW'(DEPTH-1)) ? '0 : rp + 1'b1;
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : apf_fifo
`default_nettype wire

// >>> hdl/apf_port.sv
`default_nettype none
module apf_port
    import apf_pkg::*;
#(
    parameter int WIDTH = APF_DATA_W,
    parameter int DEPTH = APF_FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [1:0] port_mode,
    input wire apf_strobes_t strobes,
    input wire apf_usb_state_t usb_state,
    input wire logic [WIDTH-1:0] fifo_data_pins_in,
    output logic [WIDTH-1:0] fifo_data_pins_out,
    output logic fifo_data_pins_oe,
    output logic rx_data_available_n_out,
    output logic rx_data_available_n_oe,
    output logic tx_space_available_n_out,
    output logic tx_space_available_n_oe,
    input wire logic usb_rx_valid,
    output logic usb_rx_ready,
    input wire logic [WIDTH-1:0] usb_rx_data,
    output logic usb_tx_valid,
    input wire logic usb_tx_ready,
    output logic [WIDTH-1:0] usb_tx_data,
    output logic send_now,
    output logic resume_request
);
    logic rd_d;
    logic wr_d;
    logic wake_d;
    logic [WIDTH-1:0] rx_hold;
    logic rx_hold_valid;
    logic tx_ready_in;
    logic rx_out_valid;
    logic [WIDTH-1:0] rx_out_data;
    logic in_reset;

    wire enabled = (port_mode == APF_MODE_ASYNC_FIFO);
    wire rd_fall = enabled && rd_d && !strobes.rd_n;
    wire rd_rise = enabled && !rd_d && strobes.rd_n;
    wire wr_fall = enabled && wr_d && !strobes.wr_n;
    wire wake_fall = enabled && wake_d && !strobes.send_now_wakeup_n;
    // Holding register refills only while the host is not mid-read
    wire hold_load = !rx_hold_valid && rx_out_valid && strobes.rd_n && !rd_rise;
    wire next_rx_flag_n = !(rx_hold_valid && !rd_rise) && !hold_load;
    wire next_tx_flag_n = !tx_ready_in || wr_fall || !enabled;

    apf_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_rx_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(usb_rx_valid),
        .in_ready(usb_rx_ready),
        .in_data(usb_rx_data),
        .out_valid(rx_out_valid),
        .out_ready(hold_load),
        .out_data(rx_out_data)
    );

    // Tx FIFO back-pressure reaches the host through the space flag
    apf_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_tx_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(wr_fall && !tx_space_available_n_out),
        .in_ready(tx_ready_in),
        .in_data(fifo_data_pins_in),
        .out_valid(usb_tx_valid),
        .out_ready(usb_tx_ready),
        .out_data(usb_tx_data)
    );

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_d <= 1'b1;
            wr_d <= 1'b1;
            wake_d <= 1'b1;
            in_reset <= 1'b1;
        end else begin
            rd_d <= strobes.rd_n;
            wr_d <= strobes.wr_n;
            wake_d <= strobes.send_now_wakeup_n;
            in_reset <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_hold <= '0;
            rx_hold_valid <= 1'b0;
        end else if (rd_rise) begin
            rx_hold_valid <= 1'b0;
        end else if (hold_load) begin
            rx_hold <= rx_out_data;
            rx_hold_valid <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fifo_data_pins_out <= '0;
            fifo_data_pins_oe <= 1'b0;
            rx_data_available_n_out <= 1'b1;
            rx_data_available_n_oe <= 1'b0;
            tx_space_available_n_out <= 1'b1;
            tx_space_available_n_oe <= 1'b0;
        end else begin
            fifo_data_pins_out <= rx_hold;
            fifo_data_pins_oe <= enabled && !strobes.rd_n;
            rx_data_available_n_out <= next_rx_flag_n;
            rx_data_available_n_oe <= enabled;
            tx_space_available_n_out <= next_tx_flag_n;
            tx_space_available_n_oe <= enabled;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            send_now <= 1'b0;
            resume_request <= 1'b0;
        end else begin
            resume_request <= wake_fall && usb_state.usb_active_n && usb_state.remote_wakeup_en;
            send_now <= wake_fall && !usb_state.usb_active_n;
        end
    end

    AST_BUS_ONLY_IN_READ: assert property (@(posedge clk) disable iff (!rst_n)
        fifo_data_pins_oe |-> $past(!strobes.rd_n))
        else $error("data bus driven without read strobe");
    AST_RX_FLAG_RISES: assert property (@(posedge clk) disable iff (!rst_n)
        rd_rise |=> rx_data_available_n_out)
        else $error("receive flag not raised after read");
    AST_RX_FLAG_MEANS_DATA: assert property (@(posedge clk) disable iff (!rst_n)
        !rx_data_available_n_out |-> rx_hold_valid)
        else $error("receive flag low with nothing waiting");
    AST_TX_FULL_FLAG: assert property (@(posedge clk) disable iff (!rst_n)
        (enabled && !tx_ready_in) |=> tx_space_available_n_out)
        else $error("space flag low while transmit fifo full");
    AST_WRITE_FLAG_RISE: assert property (@(posedge clk) disable iff (!rst_n)
        wr_fall |=> tx_space_available_n_out)
        else $error("space flag not raised after write");
    AST_RESUME: assert property (@(posedge clk) disable iff (!rst_n)
        resume_request |-> $past(usb_state.usb_active_n) && $past(usb_state.remote_wakeup_en))
        else $error("resume requested while not suspended");
    AST_SEND_NOW: assert property (@(posedge clk) disable iff (!rst_n)
        (wake_fall && !usb_state.usb_active_n) |=> send_now)
        else $error("send immediate missed");
    AST_DISABLED_QUIET: assert property (@(posedge clk) disable iff (!rst_n)
        !enabled |=> !rx_data_available_n_oe && !fifo_data_pins_oe)
        else $error("port active while mode off");
    AST_BUS_DATA: assert property (@(posedge clk) disable iff (!rst_n)
        (fifo_data_pins_oe && $past(rx_hold_valid)) |-> fifo_data_pins_out == $past(rx_hold))
        else $error("bus does not show held byte");

    // Bus turn-around: the data pins follow the read strobe one cycle late
    AST_READ_DRIVES_BUS: assert property (@(posedge clk) disable iff (!rst_n)
        rd_fall |=> fifo_data_pins_oe && fifo_data_pins_out == $past(rx_hold))
        else $error("read strobe fall did not drive the held byte");
    AST_BUS_HELD_IN_READ: assert property (@(posedge clk) disable iff (!rst_n)
        fifo_data_pins_oe && $past(fifo_data_pins_oe) |-> $stable(fifo_data_pins_out))
        else $error("bus data changed during a read");
    AST_BUS_RELEASED: assert property (@(posedge clk) disable iff (!rst_n)
        strobes.rd_n |=> !fifo_data_pins_oe)
        else $error("bus still driven after read strobe rose");

    // Receive side: the held byte is frozen while the host reads it
    AST_HOLD_STEADY_IN_READ: assert property (@(posedge clk) disable iff (!rst_n)
        !strobes.rd_n |=> $stable(rx_hold))
        else $error("held byte changed while read strobe low");
    AST_RX_HOLD_CLEARED: assert property (@(posedge clk) disable iff (!rst_n)
        rd_rise |=> !rx_hold_valid)
        else $error("held byte not consumed at read end");
    AST_NEXT_BYTE_FETCHED: assert property (@(posedge clk) disable iff (!rst_n)
        (rd_rise && rx_out_valid) ##1 strobes.rd_n |=> !rx_data_available_n_out)
        else $error("next received byte not fetched after read");
    AST_RX_LOADED_FLAG: assert property (@(posedge clk) disable iff (!rst_n)
        (rx_out_valid && !rx_hold_valid && strobes.rd_n && !rd_rise) |=> !rx_data_available_n_out)
        else $error("receive flag stays high with a byte waiting");

    // Flag pins float for the first cycle out of reset and whenever the port is off
    AST_RESET_FLAGS_FLOAT: assert property (@(posedge clk) disable iff (!rst_n)
        in_reset |-> !rx_data_available_n_oe && !tx_space_available_n_oe && !fifo_data_pins_oe)
        else $error("pins driven straight out of reset");
    AST_TX_OFF_WHEN_DISABLED: assert property (@(posedge clk) disable iff (!rst_n)
        !enabled |=> !tx_space_available_n_oe)
        else $error("space flag driven while mode off");
    AST_FLAGS_DRIVEN_ENABLED: assert property (@(posedge clk) disable iff (!rst_n)
        enabled |=> rx_data_available_n_oe && tx_space_available_n_oe)
        else $error("flags not driven while mode on");

    // Transmit side: a refused write never reaches the fifo because the flag gates the push
    AST_TX_SPACE_RETURNS: assert property (@(posedge clk) disable iff (!rst_n)
        (enabled && tx_ready_in && !wr_fall) |=> !tx_space_available_n_out)
        else $error("space flag stays high with room free");
    AST_WRITE_CAPTURED: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_fall && !tx_space_available_n_out) |=> usb_tx_valid)
        else $error("accepted write not stored");
    AST_WRITE_DATA: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_fall && !tx_space_available_n_out && !usb_tx_valid) |=> usb_tx_data == $past(fifo_data_pins_in))
        else $error("stored byte differs from bus byte");

    // Wakeup strobe
    AST_WAKE_RESUME: assert property (@(posedge clk) disable iff (!rst_n)
        (wake_fall && usb_state.usb_active_n && usb_state.remote_wakeup_en) |=> resume_request)
        else $error("resume request missed");
    AST_SEND_NOW_ACTIVE_ONLY: assert property (@(posedge clk) disable iff (!rst_n)
        send_now |-> !$past(usb_state.usb_active_n))
        else $error("send immediate while suspended");
    AST_NO_WAKE_NO_PULSE: assert property (@(posedge clk) disable iff (!rst_n)
        !wake_fall |=> !send_now && !resume_request)
        else $error("wakeup pulse without strobe");
endmodule : apf_port
`default_nettype wire

// >>> bench/apf_host.sv
`default_nettype none
module apf_host
    import apf_pkg::*;
(
    input wire logic clk,
    input wire logic rx_n,
    input wire logic tx_n,
    input wire logic [7:0] bus,
    output apf_strobes_t stb,
    output logic [7:0] dq
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        stb = '1;
        dq = 8'h00;
    end
    // A strobe starts only after its flag reads low
    task automatic wt(input logic rx, output logic ok);
        int i;
        i = 0;
        #1;
        while ((rx ? rx_n : tx_n) !== 1'b0 && i < 20) begin
            @(posedge clk);
            #1;
            i++;
        end
        ok = ((rx ? rx_n : tx_n) === 1'b0);
        @(posedge clk);
    endtask : wt
    task automatic rd(output logic [7:0] v, output logic ok);
        wt(1'b1, ok);
        stb.rd_n <= ~ok;
        repeat (3) @(posedge clk);
        #1 v = bus;
        @(posedge clk);
        stb.rd_n <= 1'b1;
        // Return right after the release edge so the caller sees the raised flag
        @(posedge clk);
        #1;
    endtask : rd
    task automatic wr(input logic [7:0] v, output logic ok);
        wt(1'b0, ok);
        dq <= v;
        stb.wr_n <= ~ok;
        @(posedge clk);
        stb.wr_n <= 1'b1;
        @(posedge clk);
    endtask : wr
    task automatic wake();
        stb.send_now_wakeup_n <= 1'b0;
        @(posedge clk);
        stb.send_now_wakeup_n <= 1'b1;
        repeat (4) @(posedge clk);
    endtask : wake
endmodule : apf_host
`default_nettype wire

// >>> bench/apf_port_tb_top.sv
`default_nettype none
module apf_port_tb_top
    import apf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n, rxv, txr, ok;
    logic [1:0] mode;
    logic [7:0] rxd, v;
    apf_usb_state_t us;
    wire apf_strobes_t stb;
    wire logic [7:0] dout, txd, dq, bus;
    wire logic doe, rxo, rxoe, txo, txoe, rxr, txv, sn, rr, rx_n, tx_n;
    int n_fail = 0;
    int cmp_count = 0;
    int n_sn, n_rr, i, k;
    logic [7:0] q[$], tq[$], got[$];
    // Pull-ups hold the flags inactive while undriven
    assign rx_n = rxoe ? rxo : 1'b1;
    assign tx_n = txoe ? txo : 1'b1;
    assign bus = doe ? dout : dq;
    apf_port apf_port_i (.clk(clk), .rst_n(rst_n), .port_mode(mode), .strobes(stb), .usb_state(us),
        .fifo_data_pins_in(bus), .fifo_data_pins_out(dout), .fifo_data_pins_oe(doe),
        .rx_data_available_n_out(rxo), .rx_data_available_n_oe(rxoe), .tx_space_available_n_out(txo),
        .tx_space_available_n_oe(txoe), .usb_rx_valid(rxv), .usb_rx_ready(rxr), .usb_rx_data(rxd),
        .usb_tx_valid(txv), .usb_tx_ready(txr), .usb_tx_data(txd), .send_now(sn), .resume_request(rr));
    apf_host apf_host_i (.clk(clk), .rx_n(rx_n), .tx_n(tx_n), .bus(bus), .stb(stb), .dq(dq));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(negedge clk) begin
        if (txv === 1'b1 && txr) got.push_back(txd);
        if (sn === 1'b1) n_sn++;
        if (rr === 1'b1) n_rr++;
    end
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic final_report();
        if (n_fail == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : final_report
    initial begin
        #100us;
        n_fail++;
        final_report();
    end
    initial begin
        void'($urandom(32'h3928));
        rst_n = 1'b0;
        mode = APF_MODE_ASYNC_FIFO;
        us = '0;
        rxv = 1'b0;
        rxd = 8'h00;
        txr = 1'b0;
        repeat (16) @(posedge clk);
        chk(8'({rxoe, txoe, doe}), 8'h00);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        rxv <= 1'b1;
        rxd <= 8'($urandom);
        for (i = 0; i < 20; i++) begin
            @(negedge clk);
            ok = rxr;
            if (ok) q.push_back(rxd);
            @(posedge clk);
            if (ok) rxd <= 8'($urandom);
        end
        rxv <= 1'b0;
        // The holding byte in front of the receive fifo adds one place
        chk(8'(q.size()), 8'(APF_FIFO_DEPTH + 1));
        while (q.size() > 0) begin
            apf_host_i.rd(v, ok);
            chk(v, q.pop_front());
            chk(8'({doe, rx_n}), 8'h01);
        end
        apf_host_i.rd(v, ok);
        chk(8'(ok), 8'h00);
        for (i = 0; i < 17; i++) begin
            v = 8'($urandom);
            apf_host_i.wr(v, ok);
            if (ok) tq.push_back(v);
        end
        chk(8'(tq.size()), 8'h10);
        chk(8'(tx_n), 8'h01);
        for (i = 0; i < 80; i++) begin
            @(posedge clk);
            txr <= (i > 50) | 1'($urandom);
        end
        chk(8'(got.size()), 8'h10);
        while (got.size() > 0 && tq.size() > 0) chk(got.pop_front(), tq.pop_front());
        chk(8'(tx_n), 8'h00);
        for (k = 0; k < 3; k++) begin
            us <= (k == 0) ? 2'b00 : ((k == 1) ? 2'b11 : 2'b10);
            @(posedge clk);
            n_sn = 0;
            n_rr = 0;
            apf_host_i.wake();
            chk(8'(n_sn * 2 + n_rr), (k == 0) ? 8'h02 : ((k == 1) ? 8'h01 : 8'h00));
        end
        mode <= APF_MODE_OFF;
        repeat (3) @(posedge clk);
        chk(8'({rxoe, txoe}), 8'h00);
        final_report();
    end
endmodule : apf_port_tb_top
`default_nettype wire
